//--- hw/pbsc_pkg.sv
// ==========================================================================
// Push-button reset and ship control constants
package pbsc_pkg;
    // ======================================================================
    // Register offsets
    localparam logic [7:0] PBSC_OFS_TIMING = 8'h30;
    localparam logic [7:0] PBSC_OFS_CTRL0  = 8'h35;
    localparam logic [7:0] PBSC_OFS_CTRL1  = 8'h36;
    // Reset values
    localparam logic [7:0] PBSC_RST_TIMING = 8'h2e;
    localparam logic [7:0] PBSC_RST_CTRL0  = 8'h20;
    localparam logic [7:0] PBSC_RST_CTRL1  = 8'h00;
    // ======================================================================
    // Field positions, timing register
    localparam int PBSC_B_NEED_VIN = 7;
    localparam int PBSC_B_WAKE1    = 6;
    localparam int PBSC_B_WAKE2    = 5;
    localparam int PBSC_B_WARN_LO  = 3;
    localparam int PBSC_B_HOLD_LO  = 1;
    // Field positions, control 0
    localparam int PBSC_B_SHIP     = 7;
    localparam int PBSC_B_RESTART_LO = 4;
    localparam int PBSC_B_GMASK    = 2;
    localparam int PBSC_B_PCYC     = 1;
    localparam int PBSC_B_SOFT     = 0;
    // Field positions, control 1
    localparam int PBSC_B_ACT_LO   = 6;
    // ======================================================================
    // Clock in kHz, timing in milliseconds
    localparam int PBSC_CLK_KHZ      = 100000;
    localparam int PBSC_TICK_MS      = 1;
    localparam int PBSC_WAKE1_S0_MS  = 125;
    localparam int PBSC_WAKE1_S1_MS  = 500;
    localparam int PBSC_WAKE2_S0_MS  = 1000;
    localparam int PBSC_WAKE2_S1_MS  = 2000;
    localparam int PBSC_WARN_STEP_MS = 500;
    localparam int PBSC_HOLD0_MS     = 4000;
    localparam int PBSC_HOLD1_MS     = 8000;
    localparam int PBSC_HOLD2_MS     = 10000;
    localparam int PBSC_HOLD3_MS     = 14000;
    localparam int PBSC_RST0_MS      = 600;
    localparam int PBSC_RST1_MS      = 1200;
    localparam int PBSC_RST2_MS      = 2400;
    localparam int PBSC_RST3_MS      = 5000;
    localparam int PBSC_OFF_MS       = 10;
    // Cycles per millisecond tick
    localparam int PBSC_TICK_CYC     = PBSC_CLK_KHZ * PBSC_TICK_MS;
    // Long-hold action codes
    localparam logic [1:0] PBSC_ACT_PCYC = 2'h0;
    localparam logic [1:0] PBSC_ACT_NONE = 2'h1;
    // Sequencer states
    typedef enum logic [1:0] {
        PBSC_ON   = 2'b00,
        PBSC_OFF  = 2'b01,
        PBSC_SHIP = 2'b10
    } pbsc_state_e;
endpackage : pbsc_pkg

//--- hw/pbsc_tick.sv
`timescale 1ns/10ps
// ==========================================================================
// Millisecond tick divider
module pbsc_tick #(
    parameter int DIV = 100000
) (
    // Clock and control
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // Tick output
    output logic      tick
);
    logic [31:0] cnt_r;      // Divider count
    assign tick = ce && (cnt_r == 32'(DIV - 1));
    // Wrap at the divide value
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 32'h0;
        end else if (ce) begin
            cnt_r <= tick ? 32'h0 : cnt_r + 32'h1;
        end
    end
endmodule : pbsc_tick

//--- hw/pbsc_top.sv
`timescale 1ns/10ps
// Summary of operation
// - Supply-gating bit requires valid supply for reset
// - First wake threshold 125 ms or 500 ms
// - Second wake threshold 1 s or 2 s
// - Warning precedes reset by 0.5-2.0 s
// - Long-hold reset 4, 8, 10, 14 s
// - Ship mode when supply invalid, button high
// - Restart delay 0.6, 1.2, 2.4, 5 s
// - Global mask forces IRQ_OUT_N high; the event outputs stay unmasked
// - Power-cycle bit cycles rails, restores defaults
// - Soft-default bit restores registers, rails stay
// - Long-hold action: cycle, none, or ship
module pbsc_top
    import pbsc_pkg::*;
#(
    parameter int TICK_CYC = pbsc_pkg::PBSC_TICK_CYC,
    parameter int DEGL_MS  = 2
) (
    // Clock, reset, enable
    input  wire logic       MCLK,
    input  wire logic       SYS_RST,
    input  wire logic       CE,
    // Register port
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    // Pins
    input  wire logic       PUSHBUTTON_INPUT_N,
    input  wire logic       SUPPLY_GOOD,
    input  wire logic       IRQ_IN_N,
    // Outputs
    output logic            IRQ_OUT_N,
    output logic            RAILS_ON,
    output logic            SHIP_MODE,
    output logic            WAKE1_EVT,
    output logic            WAKE2_EVT,
    output logic            WARN_EVT,
    output logic            LONG_HOLD_EVT
);
    // ======================================================================
    // Registers and pin synchronisers
    logic [7:0]  timing_r, ctrl0_r, ctrl1_r;
    logic [1:0]  pb_sy_r, vin_sy_r, irq_sy_r;
    logic        pb_degl_r;                // Deglitched button, 1 = pressed
    logic [7:0]  degl_cnt_r;
    logic [15:0] hold_ms_r;                // Continuous pressed time
    logic [15:0] wait_ms_r;                // Off or restart delay count
    logic        wake1_r, wake2_r, warn_r, long_r, irq_r;
    pbsc_state_e state_r;
    logic        tick;

    pbsc_tick #(.DIV(TICK_CYC)) u_tick (
        .clk  (MCLK),
        .rst  (SYS_RST),
        .ce   (CE),
        .tick (tick)
    );

    // ======================================================================
    // Threshold decode
    function automatic logic [15:0] hold_ms(input logic [1:0] s);
        case (s)
            2'h0:    hold_ms = 16'(PBSC_HOLD0_MS);
            2'h1:    hold_ms = 16'(PBSC_HOLD1_MS);
            2'h2:    hold_ms = 16'(PBSC_HOLD2_MS);
            default: hold_ms = 16'(PBSC_HOLD3_MS);
        endcase
    endfunction : hold_ms

    function automatic logic [15:0] restart_ms(input logic [1:0] s);
        case (s)
            2'h0:    restart_ms = 16'(PBSC_RST0_MS);
            2'h1:    restart_ms = 16'(PBSC_RST1_MS);
            2'h2:    restart_ms = 16'(PBSC_RST2_MS);
            default: restart_ms = 16'(PBSC_RST3_MS);
        endcase
    endfunction : restart_ms

    wire pb_pressed = !pb_sy_r[1];
    wire vin_ok     = vin_sy_r[1];
    wire [15:0] wake1_th = timing_r[PBSC_B_WAKE1] ? 16'(PBSC_WAKE1_S1_MS)
                                                   : 16'(PBSC_WAKE1_S0_MS);
    wire [15:0] wake2_th = timing_r[PBSC_B_WAKE2] ? 16'(PBSC_WAKE2_S1_MS)
                                                   : 16'(PBSC_WAKE2_S0_MS);
    wire [15:0] long_th  = hold_ms(timing_r[PBSC_B_HOLD_LO +: 2]);
    wire [15:0] warn_off = 16'(PBSC_WARN_STEP_MS)
                         * {14'h0, timing_r[PBSC_B_WARN_LO +: 2]}
                         + 16'(PBSC_WARN_STEP_MS);
    wire [15:0] warn_th  = long_th - warn_off;
    // Long-hold event needs supply valid at the threshold when gating is set; a later supply does not fire it
    wire long_ok = !timing_r[PBSC_B_NEED_VIN] || vin_ok;
    wire [1:0] act = ctrl1_r[PBSC_B_ACT_LO +: 2];
    wire [1:0] restart_sel = ctrl0_r[PBSC_B_RESTART_LO +: 2];
    wire hit_long = tick && pb_degl_r && (hold_ms_r + 16'h1 == long_th)
                    && long_ok && (state_r == PBSC_ON);
    wire do_cycle = hit_long && (act == PBSC_ACT_PCYC);
    wire do_ship_hold = hit_long && act[1];
    wire ship_cond = ctrl0_r[PBSC_B_SHIP] && !vin_ok && !pb_pressed;
    wire wr_c0 = REG_WR && (REG_ADDR == PBSC_OFS_CTRL0);
    wire req_pcyc = wr_c0 && REG_WDATA[PBSC_B_PCYC];
    wire req_soft = wr_c0 && REG_WDATA[PBSC_B_SOFT];
    wire to_default = req_pcyc || req_soft || do_cycle;

    // Read mux, unmapped reads zero
    assign REG_RDATA = (REG_ADDR == PBSC_OFS_TIMING) ? timing_r :
                       (REG_ADDR == PBSC_OFS_CTRL0)  ? ctrl0_r  :
                       (REG_ADDR == PBSC_OFS_CTRL1)  ? ctrl1_r  : 8'h00;

    // ======================================================================
    // Synchronisers; first stage read only by second
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pb_sy_r  <= 2'h3;
            vin_sy_r <= 2'h0;
            irq_sy_r <= 2'h3;
        end else if (CE) begin
            pb_sy_r  <= {pb_sy_r[0], PUSHBUTTON_INPUT_N};
            vin_sy_r <= {vin_sy_r[0], SUPPLY_GOOD};
            irq_sy_r <= {irq_sy_r[0], IRQ_IN_N};
        end
    end

    // Deglitch: level must stand for DEGL_MS ticks
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pb_degl_r  <= 1'b0;
            degl_cnt_r <= 8'h0;
        end else if (CE) begin
            if (pb_pressed == pb_degl_r) begin
                degl_cnt_r <= 8'h0;
            end else if (tick) begin
                if (degl_cnt_r == 8'(DEGL_MS - 1)) begin
                    pb_degl_r  <= pb_pressed;
                    degl_cnt_r <= 8'h0;
                end else begin
                    degl_cnt_r <= degl_cnt_r + 8'h1;
                end
            end
        end
    end

    // ======================================================================
    // Hold timer and threshold pulses; release cancels
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            hold_ms_r <= 16'h0;
            wake1_r   <= 1'b0;
            wake2_r   <= 1'b0;
            warn_r    <= 1'b0;
            long_r    <= 1'b0;
        end else if (CE) begin
            wake1_r <= 1'b0;
            wake2_r <= 1'b0;
            warn_r  <= 1'b0;
            long_r  <= hit_long;
            if (!pb_degl_r) begin
                hold_ms_r <= 16'h0;
            end else if (tick && hold_ms_r != 16'hffff) begin
                hold_ms_r <= hold_ms_r + 16'h1;
                wake1_r <= (hold_ms_r + 16'h1 == wake1_th);
                wake2_r <= (hold_ms_r + 16'h1 == wake2_th);
                warn_r  <= (hold_ms_r + 16'h1 == warn_th);
            end
        end
    end

    // ======================================================================
    // Register file; defaults restored by any reset request
    always_ff @(posedge MCLK) begin
        if (SYS_RST || (CE && to_default)) begin
            timing_r <= PBSC_RST_TIMING;
            ctrl0_r  <= PBSC_RST_CTRL0;
            ctrl1_r  <= PBSC_RST_CTRL1;
        end else if (CE && REG_WR) begin
            if (REG_ADDR == PBSC_OFS_TIMING) timing_r <= REG_WDATA;
            if (REG_ADDR == PBSC_OFS_CTRL0)  ctrl0_r  <= REG_WDATA;
            if (REG_ADDR == PBSC_OFS_CTRL1)  ctrl1_r  <= REG_WDATA;
        end
    end

    // ======================================================================
    // Rail sequencer: on, off (restart delay), ship
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_r   <= PBSC_ON;
            wait_ms_r <= 16'h0;
        end else if (CE) begin
            case (state_r)
                PBSC_ON: begin
                    if (do_cycle) begin
                        state_r   <= PBSC_OFF;
                        wait_ms_r <= restart_ms(restart_sel);
                    end else if (req_pcyc) begin
                        state_r   <= PBSC_OFF;
                        wait_ms_r <= 16'(PBSC_OFF_MS);
                    end else if (ship_cond || do_ship_hold) begin
                        state_r <= PBSC_SHIP;
                    end
                end
                PBSC_OFF: begin
                    // One extra tick: the first one may be partial, so the
                    // rails stay off at least the full delay
                    if (tick) begin
                        if (wait_ms_r == 16'h0) state_r <= PBSC_ON;
                        else wait_ms_r <= wait_ms_r - 16'h1;
                    end
                end
                PBSC_SHIP: begin
                    // Wake on a fresh press or supply; the hold that
                    // entered ship has a nonzero count and must not wake it
                    if ((pb_degl_r && hold_ms_r == 16'h0) || vin_ok) state_r <= PBSC_ON;
                end
                default: state_r <= PBSC_ON;
            endcase
        end
    end

    // Interrupt output masked globally
    always_ff @(posedge MCLK) begin
        if (SYS_RST) irq_r <= 1'b1;
        else if (CE) irq_r <= irq_sy_r[1] | ctrl0_r[PBSC_B_GMASK];
    end

    assign IRQ_OUT_N     = irq_r;
    assign RAILS_ON      = (state_r == PBSC_ON);
    assign SHIP_MODE     = (state_r == PBSC_SHIP);
    assign WAKE1_EVT     = wake1_r;
    assign WAKE2_EVT     = wake2_r;
    assign WARN_EVT      = warn_r;
    assign LONG_HOLD_EVT = long_r;

    // ======================================================================
    // Checks
    mask_blocks_irq_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        CE && ctrl0_r[PBSC_B_GMASK] |=> IRQ_OUT_N)
        else $error("irq not masked");
    soft_keeps_rails_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        CE && req_soft && !req_pcyc && !do_cycle && RAILS_ON && !ship_cond && !do_ship_hold
        |=> RAILS_ON && ctrl0_r == PBSC_RST_CTRL0)
        else $error("soft default wrong");
    pcyc_off_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        CE && req_pcyc && RAILS_ON |=> !RAILS_ON && !ctrl0_r[PBSC_B_PCYC])
        else $error("power cycle wrong");
    release_clears_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        CE && !pb_degl_r |=> hold_ms_r == 16'h0)
        else $error("hold not cancelled");
    ship_hold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        CE && do_ship_hold && !req_pcyc |=> SHIP_MODE)
        else $error("long hold did not enter ship");
    restart_load_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        CE && do_cycle |=> !RAILS_ON && wait_ms_r == restart_ms($past(restart_sel)))
        else $error("restart delay wrong");
    ship_entry_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        CE && ship_cond && !req_pcyc && !do_cycle && state_r == PBSC_ON |=> SHIP_MODE)
        else $error("ship request ignored");
endmodule : pbsc_top

//--- verif/pbsc_user_model.sv
`timescale 1ns/10ps
// ==========
// User button and input supply model
module pbsc_user_model #(
    parameter int TICK = 2
) (
    // Clock
    input  wire logic clk,
    // Pins
    output logic      pb_n,
    output logic      supply_ok
);
    // Idle: button released, supply absent
    initial begin
        pb_n      = 1'b1;
        supply_ok = 1'b0;
    end
    // Hold the button low for a number of ms, changed off the sampling edge
    task automatic press(input int ms);
        @(negedge clk) pb_n = 1'b0;
        repeat (ms * TICK) @(negedge clk);
        pb_n = 1'b1;
        // Let the release pass the deglitch before any next press
        repeat (10 * TICK) @(negedge clk);
    endtask : press
    // Supply goes valid or invalid
    task automatic supply(input logic v);
        @(negedge clk) supply_ok = v;
    endtask : supply
endmodule : pbsc_user_model

//--- verif/tb_pushbutton_reset_ship_control.sv
`timescale 1ns/10ps
// ==========
// Bench for push-button reset and ship control
module tb_pushbutton_reset_ship_control;
    import pbsc_pkg::*;
    localparam int TICK  = 2;     // Cycles per ms, shortened to keep holds cheap
    localparam int DEGL  = 2;     // Deglitch in ms
    localparam int LIMIT = 95000; // Hang ceiling in cycles
    // Design pins
    logic       mclk, sys_rst, ce, reg_wr, irq_in_n, pb_n, sup_ok;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       irq_out_n, rails_on, ship, w1, w2, wn, lh;
    // Bookkeeping
    int         bad_count, cmp_count, cyc;
    int         t_w1, t_w2, t_wn, t_lh, t_pf, t_rf, t_rr;
    logic       rails_q = 1'b1;
    logic       pb_q    = 1'b1;
    // ==========
    // Design and partner
    pbsc_top #(.TICK_CYC(TICK), .DEGL_MS(DEGL)) i_pbsc_top (
        .MCLK(mclk), .SYS_RST(sys_rst), .CE(ce), .REG_WR(reg_wr),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .PUSHBUTTON_INPUT_N(pb_n), .SUPPLY_GOOD(sup_ok), .IRQ_IN_N(irq_in_n),
        .IRQ_OUT_N(irq_out_n), .RAILS_ON(rails_on), .SHIP_MODE(ship),
        .WAKE1_EVT(w1), .WAKE2_EVT(w2), .WARN_EVT(wn), .LONG_HOLD_EVT(lh));
    pbsc_user_model #(.TICK(TICK)) i_pbsc_user_model (
        .clk(mclk), .pb_n(pb_n), .supply_ok(sup_ok));
    // Clock at 100 MHz
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Stamp events; outputs sampled before this edge's updates land
    always @(posedge mclk) begin
        cyc++;
        if (w1 === 1'b1) t_w1 = cyc;
        if (w2 === 1'b1) t_w2 = cyc;
        if (wn === 1'b1) t_wn = cyc;
        if (lh === 1'b1) t_lh = cyc;
        if (pb_q === 1'b1 && pb_n === 1'b0) t_pf = cyc;
        if (rails_q === 1'b1 && rails_on === 1'b0) t_rf = cyc;
        if (rails_q === 1'b0 && rails_on === 1'b1) t_rr = cyc;
        rails_q = rails_on;
        pb_q = pb_n;
    end
    // ==========
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic rng(input int v, input int lo, input int hi);
        chk(32'(v >= lo && v <= hi), 32'h1);
    endtask : rng
    // Write strobe for one cycle, then one idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk) reg_wr = 1'b0;
        @(negedge mclk);
    endtask : wr
    // Read is combinational; look after it settles
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        #1 chk(32'(reg_rdata), 32'(exp));
        // Return on a falling edge so the next drive lands there
        @(negedge mclk);
    endtask : rd
    task automatic clr();
        {t_w1, t_w2, t_wn, t_lh, t_rf, t_rr} = '0;
    endtask : clr
    // Bounded wait for rails back on
    task automatic wait_rails(input int ms);
        for (int i = 0; i < ms * TICK && rails_on !== 1'b1; i++) @(negedge mclk);
        // Let the edge that stamps the rise pass
        @(negedge mclk);
    endtask : wait_rails
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    // ==========
    // Scenarios
    task automatic t_regs();
        rd(PBSC_OFS_TIMING, PBSC_RST_TIMING);
        rd(PBSC_OFS_CTRL0, PBSC_RST_CTRL0);
        rd(PBSC_OFS_CTRL1, PBSC_RST_CTRL1);
        wr(8'h31, 8'hff);
        rd(8'h31, 8'h00);
        done("regs");
    endtask : t_regs
    // Frozen enable ignores a soft request; mid-run reset restores defaults
    task automatic t_ce_rst();
        wr(PBSC_OFS_TIMING, 8'h00);
        ce = 1'b0;
        wr(PBSC_OFS_CTRL0, 8'h01);
        ce = 1'b1;
        rd(PBSC_OFS_TIMING, 8'h00);
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        rd(PBSC_OFS_TIMING, PBSC_RST_TIMING);
        done("enable and reset");
    endtask : t_ce_rst
    task automatic t_mask();
        irq_in_n = 1'b0;
        repeat (5) @(negedge mclk);
        chk(32'(irq_out_n), 32'h0);
        wr(PBSC_OFS_CTRL0, 8'h24);
        repeat (5) @(negedge mclk);
        chk(32'(irq_out_n), 32'h1);
        irq_in_n = 1'b1;
        wr(PBSC_OFS_CTRL0, 8'h20);
        done("mask");
    endtask : t_mask
    // Soft default keeps rails, power cycle drops them 10 ms
    task automatic t_defaults();
        clr();
        wr(PBSC_OFS_TIMING, 8'h00);
        wr(PBSC_OFS_CTRL0, 8'h01);
        rd(PBSC_OFS_TIMING, PBSC_RST_TIMING);
        rd(PBSC_OFS_CTRL0, PBSC_RST_CTRL0);
        chk(32'(t_rf), 32'h0);
        wr(PBSC_OFS_CTRL1, 8'h40);
        wr(PBSC_OFS_CTRL0, 8'h02);
        wait_rails(50);
        rng((t_rr - t_rf) / TICK, 10, 12);
        rd(PBSC_OFS_CTRL1, PBSC_RST_CTRL1);
        rd(PBSC_OFS_CTRL0, PBSC_RST_CTRL0);
        done("defaults");
    endtask : t_defaults
    // One long press with action none; event spacing is exact in ms ticks
    task automatic hold(input logic [7:0] tim, input int e1, input int e2, input int en);
        wr(PBSC_OFS_TIMING, tim);
        wr(PBSC_OFS_CTRL1, 8'h40);
        clr();
        i_pbsc_user_model.press(4100);
        chk(t_lh - t_wn, en * TICK);
        chk(t_lh - t_w2, e2 * TICK);
        chk(t_lh - t_w1, e1 * TICK);
        rng((t_lh - t_pf) / TICK, 4000, 4000 + DEGL + 3);
        chk(32'(rails_on), 32'h1);
    endtask : hold
    task automatic t_hold();
        for (int c = 0; c < 4; c++) begin
            hold({1'b0, c[0], c[1], c[1:0], 3'b000}, 4000 - (c[0] ? 500 : 125),
                 4000 - (c[1] ? 2000 : 1000), 500 * (c + 1));
        end
        wr(PBSC_OFS_TIMING, 8'h00);
        clr();
        i_pbsc_user_model.press(300);
        repeat (10 * TICK) @(negedge mclk);
        chk(32'(t_w1 != 0), 32'h1);
        chk(t_w2, 32'h0);
        chk(t_lh, 32'h0);
        done("hold");
    endtask : t_hold
    // Supply gating, then a power-cycle long hold with 0.6 s restart
    task automatic t_gate();
        wr(PBSC_OFS_TIMING, 8'h80);
        wr(PBSC_OFS_CTRL0, 8'h00);
        wr(PBSC_OFS_CTRL1, 8'h00);
        clr();
        i_pbsc_user_model.press(4100);
        chk(t_lh, 32'h0);
        chk(32'(rails_on), 32'h1);
        chk(32'(ship), 32'h0);
        i_pbsc_user_model.supply(1'b1);
        clr();
        i_pbsc_user_model.press(4100);
        wait_rails(1000);
        chk(32'(t_lh != 0), 32'h1);
        rng((t_rr - t_rf) / TICK, 600, 602);
        rd(PBSC_OFS_TIMING, PBSC_RST_TIMING);
        done("gate");
    endtask : t_gate
    task automatic t_ship();
        wr(PBSC_OFS_CTRL0, 8'h80);
        repeat (20 * TICK) @(negedge mclk);
        chk(32'(ship), 32'h0);
        i_pbsc_user_model.supply(1'b0);
        for (int i = 0; i < 20 * TICK && ship !== 1'b1; i++) @(negedge mclk);
        chk(32'(ship), 32'h1);
        i_pbsc_user_model.supply(1'b1);
        for (int i = 0; i < 20 * TICK && ship !== 1'b0; i++) @(negedge mclk);
        chk(32'(ship), 32'h0);
        done("ship");
    endtask : t_ship
    // Long hold with ship action; a fresh short press wakes it
    task automatic t_lship();
        wr(PBSC_OFS_CTRL0, PBSC_RST_CTRL0);
        wr(PBSC_OFS_TIMING, 8'h00);
        wr(PBSC_OFS_CTRL1, 8'h80);
        i_pbsc_user_model.supply(1'b0);
        clr();
        i_pbsc_user_model.press(4100);
        chk(32'(t_lh != 0), 32'h1);
        chk(32'(ship), 32'h1);
        i_pbsc_user_model.press(5);
        chk(32'(ship), 32'h0);
        chk(32'(rails_on), 32'h1);
        done("long ship");
    endtask : t_lship
    // ==========
    // Closing report
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        irq_in_n = 1'b1;
        repeat (5) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        t_regs();
        t_ce_rst();
        t_mask();
        t_defaults();
        t_hold();
        t_gate();
        t_ship();
        t_lship();
        tally_and_finish();
    end
    // Hang guard
    initial begin
        repeat (LIMIT) @(posedge mclk);
        bad_count++;
        $display("BAD t=%0t timeout", $time);
        tally_and_finish();
    end
endmodule : tb_pushbutton_reset_ship_control
